// >>> rtl/temp_sensor_pkg.sv
// shared constants and types for the temperature sensor serial target
package temp_sensor_pkg;

   // ****************************************
   // target addresses (hi pin, lo pin)
   // ****************************************
   localparam logic [6:0] TADDR_LL   = 7'h48;
   localparam logic [6:0] TADDR_LF   = 7'h49;
   localparam logic [6:0] TADDR_LH   = 7'h4a;
   localparam logic [6:0] TADDR_HL   = 7'h4c;
   localparam logic [6:0] TADDR_HF   = 7'h4d;
   localparam logic [6:0] TADDR_HH   = 7'h4e;
   localparam logic [6:0] TADDR_FL   = 7'h4b;
   localparam logic [6:0] TADDR_FH   = 7'h4f;
   localparam logic [6:0] TADDR_RST  = 7'h48;

   // ****************************************
   // bus codes
   // ****************************************
   localparam logic [6:0] GC_ADDR    = 7'h00;
   localparam logic [7:0] GC_LATCH   = 8'h04;
   localparam logic [7:0] GC_RESET   = 8'h06;
   localparam logic [7:0] HS_MASK    = 8'hf8;
   localparam logic [7:0] HS_CODE    = 8'h08;
   localparam logic [3:0] BYTE_BITS  = 4'h8;

   // ****************************************
   // register map and result format
   // ****************************************
   localparam logic [1:0]  PTR_TEMP   = 2'h0;
   localparam logic [11:0] TEMP_RST   = 12'h000;
   localparam logic [11:0] TEMP_MAX   = 12'h7ff;
   localparam logic [11:0] TEMP_MIN   = 12'h800;
   localparam logic [3:0]  TEMP_PAD   = 4'h0;
   localparam logic [7:0]  READ_NONE  = 8'h00;
   localparam logic [11:0] RES_MASK9  = 12'hff8;
   localparam logic [11:0] RES_MASK10 = 12'hffc;
   localparam logic [11:0] RES_MASK11 = 12'hffe;
   localparam logic [11:0] RES_MASK12 = 12'hfff;
   localparam logic [1:0]  INIT_WAIT  = 2'h3;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic flt;
      logic lvl;
   } tri_pin_s;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK,
      ST_GC_BYTE, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
   } bus_state_e;

endpackage

// >>> rtl/addr_select.sv
// tri-level address pin decoder with latched target address
`timescale 1ns/1ps
module addr_select
   import temp_sensor_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // pins and control
   input  wire tri_pin_s   pin_lo_i,
   input  wire tri_pin_s   pin_hi_i,
   input  wire logic       one_pin_i,
   input  wire logic       load_i,
   // latched address
   output logic [6:0]      addr_o
);

   logic [6:0] two_pin_addr;
   logic [6:0] one_pin_addr;
   logic [6:0] addr_next;

   // ****************************************
   // decode
   // ****************************************
   always_comb begin
      case ({pin_hi_i, pin_lo_i})
         4'b0000: two_pin_addr = TADDR_LL;
         4'b0010: two_pin_addr = TADDR_LF;
         4'b0001: two_pin_addr = TADDR_LH;
         4'b0100: two_pin_addr = TADDR_HL;
         4'b0110: two_pin_addr = TADDR_HF;
         4'b0101: two_pin_addr = TADDR_HH;
         4'b1000: two_pin_addr = TADDR_FL;
         4'b1001: two_pin_addr = TADDR_FH;
         default: two_pin_addr = TADDR_RST;
      endcase
   end

   assign one_pin_addr = pin_lo_i.flt ? TADDR_LF :
                         (pin_lo_i.lvl ? TADDR_LH : TADDR_LL);
   assign addr_next    = one_pin_i ? one_pin_addr : two_pin_addr;

   // ****************************************
   // latch: pins are not sensed between loads
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_o <= TADDR_RST;
      end else if (load_i) begin
         addr_o <= addr_next;
      end
   end

endmodule // addr_select

// >>> rtl/temp_result.sv
// read-only temperature result register with resolution masking
`timescale 1ns/1ps
module temp_result
   import temp_sensor_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // control
   input  wire logic              clr_i,
   input  wire logic              done_i,
   input  wire logic signed [12:0] data_i,
   input  wire logic [1:0]        res_i,
   // result
   output logic [11:0]            result_o
);

   logic [11:0] sat_val;
   logic [11:0] res_mask;
   logic [11:0] result_next;

   // wide converter input saturates rather than wrapping
   assign sat_val = (data_i > $signed({1'b0, TEMP_MAX})) ? TEMP_MAX :
                    (data_i < $signed({1'b1, TEMP_MIN})) ? TEMP_MIN :
                    data_i[11:0];

   assign res_mask = (res_i == 2'h0) ? RES_MASK9  :
                     (res_i == 2'h1) ? RES_MASK10 :
                     (res_i == 2'h2) ? RES_MASK11 : RES_MASK12;

   assign result_next = sat_val & res_mask;

   // ****************************************
   // storage: only a finished conversion or a clear writes it
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_o <= TEMP_RST;
      end else if (clr_i) begin
         result_o <= TEMP_RST;
      end else if (done_i) begin
         result_o <= result_next;
      end
   end

endmodule // temp_result

// >>> rtl/temp_sensor_i2c_target.sv
// serial bus target of the temperature sensor
// Functional notes
// - 12-bit read-only result, bus writes ignored
// - read gives two bytes, low nibble zero
// - negative temperatures are twos complement
// - result reads zero after any reset
// - resolution selectable 9 to 12 bits
// - unused low bits forced to zero
// - target only, open-drain, never drives clock
// - fast and high-speed rates accepted
// - every byte shifted MSB first
// - START begins address byte reception
// - address byte: seven bits plus direction
// - matching address acknowledged on ninth pulse
// - eight data bits then receiver acknowledge
// - data change with clock high is control
// - STOP returns target to idle
// - two-pin tri-level address map
// - one-pin tri-level address map
// - address pins latched after reset or request
// - general call relatch and reset commands
// - first written byte loads pointer
// - read high then low byte, early end
`timescale 1ns/1ps
module temp_sensor_i2c_target
   import temp_sensor_pkg::*;
(
   // clock and reset
   input  wire logic               CLK_I,
   input  wire logic               RST_N_I,
   // serial bus, open drain
   input  wire logic               SCL_I,
   output logic                    SCL_O,
   output logic                    SCL_OE_O,
   input  wire logic               SDA_I,
   output logic                    SDA_O,
   output logic                    SDA_OE_O,
   // address straps
   input  wire tri_pin_s           ADDR_SELECT_PIN_LO_I,
   input  wire tri_pin_s           ADDR_SELECT_PIN_HI_I,
   input  wire logic               ONE_PIN_VARIANT_I,
   // converter side
   input  wire logic               CONV_DONE_I,
   input  wire logic signed [12:0] CONV_DATA_I,
   input  wire logic [1:0]         RES_SEL_I,
   // status
   output logic [11:0]             TEMP_RESULT_O,
   output logic [6:0]              TARGET_ADDR_O,
   output logic                    HS_MODE_O,
   output logic                    GC_RESET_O
);

   // ****************************************
   // reset release and synchronisers
   // ****************************************
   logic       rst_meta;
   logic       rst_n;
   logic [1:0] scl_pipe;
   logic [1:0] sda_pipe;
   tri_pin_s   lo_meta;
   tri_pin_s   lo_sync;
   tri_pin_s   hi_meta;
   tri_pin_s   hi_sync;
   logic       one_meta;
   logic       one_sync;
   logic       scl_dly;
   logic       sda_dly;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // logic reads only the second stage and the scl_dly and sda_dly copies behind it
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         scl_pipe <= 2'h3;
         sda_pipe <= 2'h3;
         lo_meta  <= '0;
         lo_sync  <= '0;
         hi_meta  <= '0;
         hi_sync  <= '0;
         one_meta <= 1'b0;
         one_sync <= 1'b0;
         scl_dly  <= 1'b1;
         sda_dly  <= 1'b1;
      end else begin
         scl_pipe <= {scl_pipe[0], SCL_I};
         sda_pipe <= {sda_pipe[0], SDA_I};
         lo_meta  <= ADDR_SELECT_PIN_LO_I;
         lo_sync  <= lo_meta;
         hi_meta  <= ADDR_SELECT_PIN_HI_I;
         hi_sync  <= hi_meta;
         one_meta <= ONE_PIN_VARIANT_I;
         one_sync <= one_meta;
         scl_dly  <= scl_pipe[1];
         sda_dly  <= sda_pipe[1];
      end
   end

   // ****************************************
   // bus conditions
   // ****************************************
   wire scl_s    = scl_pipe[1];
   wire sda_s    = sda_pipe[1];
   wire scl_rise = scl_s & ~scl_dly;
   wire scl_fall = ~scl_s & scl_dly;
   wire scl_hold = scl_s & scl_dly;
   wire start_ev = scl_hold & sda_dly & ~sda_s;
   wire stop_ev  = scl_hold & ~sda_dly & sda_s;

   // ****************************************
   // registers
   // ****************************************
   bus_state_e  state_reg, state_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic [7:0]  rx_reg, rx_next;
   logic [7:0]  tx_reg, tx_next;
   logic        oe_reg, oe_next;
   logic [1:0]  ptr_reg, ptr_next;
   logic        ptr_wr_reg, ptr_wr_next;
   logic        rw_reg, rw_next;
   logic        gc_reg, gc_next;
   logic        lo_byte_reg, lo_byte_next;
   logic        hs_reg, hs_next;
   logic        gcr_reg, gcr_next;
   logic        relatch_reg, relatch_next;
   logic [1:0]  init_reg;
   logic [6:0]  own_addr;
   logic [11:0] temp_val;

   wire        byte_done = scl_fall & (cnt_reg == BYTE_BITS);
   wire [6:0]  rx_addr   = rx_reg[7:1];
   wire        addr_hit  = (rx_addr == own_addr);
   wire        gc_hit    = (rx_addr == GC_ADDR) & ~rx_reg[0];
   wire        hs_hit    = ((rx_reg & HS_MASK) == HS_CODE);
   wire [7:0]  hi_byte   = (ptr_reg == PTR_TEMP) ? temp_val[11:4] : READ_NONE;
   wire [7:0]  lo_byte   = (ptr_reg == PTR_TEMP) ? {temp_val[3:0], TEMP_PAD} :
                                                    READ_NONE;
   wire [7:0]  rd_byte   = lo_byte_reg ? lo_byte : hi_byte;
   wire        init_load = (init_reg == INIT_WAIT - 2'h1);
   wire        addr_load = init_load | relatch_reg;

   // ****************************************
   // protocol engine
   // ****************************************
   always_comb begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      rx_next      = rx_reg;
      tx_next      = tx_reg;
      oe_next      = oe_reg;
      ptr_next     = ptr_reg;
      ptr_wr_next  = ptr_wr_reg;
      rw_next      = rw_reg;
      gc_next      = gc_reg;
      lo_byte_next = lo_byte_reg;
      hs_next      = hs_reg;
      gcr_next     = 1'b0;
      relatch_next = 1'b0;
      if (stop_ev) begin
         state_next = ST_IDLE;
         oe_next    = 1'b0;
         hs_next    = 1'b0;
      end else if (start_ev) begin
         state_next = ST_ADDR;
         cnt_next   = 4'h0;
         oe_next    = 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR, ST_WR_BYTE, ST_GC_BYTE: begin
               if (scl_rise) begin
                  rx_next  = {rx_reg[6:0], sda_s};
                  cnt_next = cnt_reg + 4'h1;
               end
               if (byte_done) begin
                  oe_next = 1'b1;
                  if (state_reg == ST_ADDR) begin
                     rw_next    = rx_reg[0];
                     gc_next    = gc_hit;
                     state_next = ST_ADDR_ACK;
                     if (!(addr_hit | gc_hit)) begin
                        oe_next    = 1'b0;
                        hs_next    = hs_reg | hs_hit;
                        state_next = hs_hit ? ST_IDLE : ST_IGNORE;
                     end
                  end else if (state_reg == ST_GC_BYTE) begin
                     state_next   = ST_WR_ACK;
                     relatch_next = (rx_reg == GC_LATCH) |
                                    (rx_reg == GC_RESET);
                     gcr_next     = (rx_reg == GC_RESET);
                     if (rx_reg == GC_RESET) begin
                        ptr_next = PTR_TEMP;
                     end
                  end else begin
                     state_next  = ST_WR_ACK;
                     ptr_wr_next = 1'b0;
                     if (ptr_wr_reg) begin
                        ptr_next = rx_reg[1:0];
                     end
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_next     = 4'h0;
                  lo_byte_next = 1'b1;
                  ptr_wr_next  = 1'b1;
                  oe_next      = 1'b0;
                  state_next   = gc_reg ? ST_GC_BYTE : ST_WR_BYTE;
                  if (rw_reg & ~gc_reg) begin
                     tx_next    = {hi_byte[6:0], 1'b0};
                     oe_next    = ~hi_byte[7];
                     state_next = ST_RD_BYTE;
                  end
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  cnt_next   = 4'h0;
                  oe_next    = 1'b0;
                  state_next = ST_WR_BYTE;
               end
            end
            ST_RD_BYTE: begin
               if (scl_rise) begin
                  cnt_next = cnt_reg + 4'h1;
               end
               if (byte_done) begin
                  oe_next    = 1'b0;
                  state_next = ST_RD_ACK;
               end else if (scl_fall) begin
                  oe_next = ~tx_reg[7];
                  tx_next = {tx_reg[6:0], 1'b0};
               end
            end
            ST_RD_ACK: begin
               if (scl_rise & sda_s) begin
                  state_next = ST_IGNORE;
               end else if (scl_fall) begin
                  cnt_next     = 4'h0;
                  lo_byte_next = ~lo_byte_reg;
                  tx_next      = {rd_byte[6:0], 1'b0};
                  oe_next      = ~rd_byte[7];
                  state_next   = ST_RD_BYTE;
               end
            end
            ST_IDLE, ST_IGNORE: begin
               oe_next = 1'b0;
            end
            default: begin
               state_next = ST_IDLE;
               oe_next    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 4'h0;
         rx_reg      <= 8'h00;
         tx_reg      <= 8'h00;
         oe_reg      <= 1'b0;
         ptr_reg     <= PTR_TEMP;
         ptr_wr_reg  <= 1'b0;
         rw_reg      <= 1'b0;
         gc_reg      <= 1'b0;
         lo_byte_reg <= 1'b0;
         hs_reg      <= 1'b0;
         gcr_reg     <= 1'b0;
         relatch_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         rx_reg      <= rx_next;
         tx_reg      <= tx_next;
         oe_reg      <= oe_next;
         ptr_reg     <= ptr_next;
         ptr_wr_reg  <= ptr_wr_next;
         rw_reg      <= rw_next;
         gc_reg      <= gc_next;
         lo_byte_reg <= lo_byte_next;
         hs_reg      <= hs_next;
         gcr_reg     <= gcr_next;
         relatch_reg <= relatch_next;
      end
   end

   // ****************************************
   // startup strap capture, waits out the pin synchronisers
   // ****************************************
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         init_reg <= 2'h0;
      end else if (init_reg != INIT_WAIT) begin
         init_reg <= init_reg + 2'h1;
      end
   end

   // ****************************************
   // pin outputs: the clock line is never driven
   // ****************************************
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         SCL_O    <= 1'b0;
         SCL_OE_O <= 1'b0;
         SDA_O    <= 1'b0;
         SDA_OE_O <= 1'b0;
      end else begin
         SCL_O    <= 1'b0;
         SCL_OE_O <= 1'b0;
         SDA_O    <= 1'b0;
         SDA_OE_O <= oe_reg;
      end
   end

   assign HS_MODE_O     = hs_reg;
   assign GC_RESET_O    = gcr_reg;
   assign TEMP_RESULT_O = temp_val;
   assign TARGET_ADDR_O = own_addr;

   // ****************************************
   // submodules
   // ****************************************
   addr_select u_addr_select (
      .clk_i     (CLK_I),
      .rst_n_i   (rst_n),
      .pin_lo_i  (lo_sync),
      .pin_hi_i  (hi_sync),
      .one_pin_i (one_sync),
      .load_i    (addr_load),
      .addr_o    (own_addr)
   );

   temp_result u_temp_result (
      .clk_i    (CLK_I),
      .rst_n_i  (rst_n),
      .clr_i    (gcr_reg),
      .done_i   (CONV_DONE_I),
      .data_i   (CONV_DATA_I),
      .res_i    (RES_SEL_I),
      .result_o (temp_val)
   );

endmodule // temp_sensor_i2c_target

// >>> sim/temp_sensor_i2c_target_properties.sv
// port checker for the temperature sensor serial target
`timescale 1ns/1ps
module temp_sensor_chk
   import temp_sensor_pkg::*;
(
   // clock, reset and bus
   input wire logic               CLK_I,
   input wire logic               RST_N_I,
   input wire logic               SCL_I,
   input wire logic               SCL_O,
   input wire logic               SDA_I,
   input wire logic               SCL_OE_O,
   input wire logic               SDA_O,
   input wire logic               SDA_OE_O,
   // straps and converter
   input wire tri_pin_s           ADDR_SELECT_PIN_LO_I,
   input wire tri_pin_s           ADDR_SELECT_PIN_HI_I,
   input wire logic               ONE_PIN_VARIANT_I,
   input wire logic               CONV_DONE_I,
   input wire logic signed [12:0] CONV_DATA_I,
   input wire logic [1:0]         RES_SEL_I,
   // status
   input wire logic [11:0]        TEMP_RESULT_O,
   input wire logic [6:0]         TARGET_ADDR_O,
   input wire logic               HS_MODE_O,
   input wire logic               GC_RESET_O
);
   // ****
   // reference values
   // ****
   function automatic logic [11:0] fmt(logic signed [12:0] d, logic [1:0] r);
      logic [11:0] v;
      v = (d > 13'sd2047) ? 12'h7ff : (d < -13'sd2048) ? 12'h800 : d[11:0];
      return v & (12'hfff << (2'h3 - r));
   endfunction
   function automatic logic [6:0] amap(tri_pin_s h, tri_pin_s l, logic one);
      logic [6:0] c;
      c = l.flt ? 7'h01 : (l.lvl ? 7'h02 : 7'h00);
      if (one) return 7'h48 + c;
      if (!h.flt) return (h.lvl ? 7'h4c : 7'h48) + c;
      if (l.flt) return 7'h48;
      return l.lvl ? 7'h4f : 7'h4b;
   endfunction
   logic [11:0] exp_reg;
   logic [6:0]  pin_addr;
   assign pin_addr = amap(ADDR_SELECT_PIN_HI_I, ADDR_SELECT_PIN_LO_I, ONE_PIN_VARIANT_I);
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) exp_reg <= 12'h000;
      else if (CONV_DONE_I) exp_reg <= fmt(CONV_DATA_I, RES_SEL_I);
   end
   // ****
   // properties
   // ****
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence stop_s;
      SCL_I && $rose(SDA_I);
   endsequence
   // a clear in the window would hide the store, so it is excluded
   sequence store_s;
      CONV_DONE_I && !GC_RESET_O ##1 !CONV_DONE_I && !GC_RESET_O ##1 !GC_RESET_O;
   endsequence
   a_pins_open_drain: assert property (!SCL_OE_O && !SCL_O && !SDA_O)
      else $error("target drove a line high or the clock");
   a_data_clock_low: assert property ($changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I))
      else $error("data moved while clock high");
   a_data_hold_fall: assert property ($fell(SCL_I) |-> $stable(SDA_OE_O) [*3])
      else $error("data moved too soon after clock fall");
   a_result_store: assert property (store_s |-> TEMP_RESULT_O == exp_reg)
      else $error("stored result has wrong format");
   a_result_held: assert property ($changed(TEMP_RESULT_O) |-> $past(CONV_DONE_I) ||
      $past(CONV_DONE_I, 2) || GC_RESET_O || $past(GC_RESET_O))
      else $error("result changed without a cause");
   a_gc_clears: assert property (GC_RESET_O |-> ##[0:1] TEMP_RESULT_O == 12'h000)
      else $error("general call reset left result");
   a_gc_single: assert property (GC_RESET_O |=> !GC_RESET_O)
      else $error("reset pulse too long");
   a_addr_map: assert property ($changed(TARGET_ADDR_O) |-> TARGET_ADDR_O == pin_addr)
      else $error("latched address does not match pins");
   a_hs_stop: assert property (HS_MODE_O ##0 stop_s |-> ##[1:6] !HS_MODE_O)
      else $error("fast mode not back after stop");
endmodule // temp_sensor_chk

bind temp_sensor_i2c_target temp_sensor_chk u_chk (
   .CLK_I, .RST_N_I, .SCL_I, .SCL_O, .SDA_I, .SCL_OE_O, .SDA_O, .SDA_OE_O,
   .ADDR_SELECT_PIN_LO_I, .ADDR_SELECT_PIN_HI_I, .ONE_PIN_VARIANT_I, .CONV_DONE_I,
   .CONV_DATA_I, .RES_SEL_I, .TEMP_RESULT_O, .TARGET_ADDR_O, .HS_MODE_O, .GC_RESET_O);

// >>> sim/i2c_ctrl_model.sv
// bus controller model on the far side of the serial target
`timescale 1ns/1ps
module i2c_ctrl_model (
   // bus lines, data is open drain
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   // ****
   // framing and bit tasks
   // ****
   // 200 ns low and 100 ns high keep the target's sync margins
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic start();
      #100 sda_oe_o = 1'b0;
      #100 scl_o = 1'b1;
      #100 sda_oe_o = 1'b1;
      #100 scl_o = 1'b0;
   endtask
   task automatic stop();
      #100 sda_oe_o = 1'b1;
      #100 scl_o = 1'b1;
      #100 sda_oe_o = 1'b0;
      #300;
   endtask
   task automatic bitx(input logic t, output logic r);
      #100 sda_oe_o = ~t;
      #100 scl_o = 1'b1;
      #100 r = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] t, input logic ab, output logic [7:0] r,
                       output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--)
         bitx(t[i], r[i]);
      bitx(ab, a);
      ack = ~a;
   endtask
endmodule // i2c_ctrl_model

// >>> sim/test_temp_sensor_i2c_target.sv
// self-checking bench for the temperature sensor serial target
`timescale 1ns/1ps
`define CHK(e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got %h want %h", $time, a, e); end end
module test_temp_sensor_i2c_target
   import temp_sensor_pkg::*;
;
   typedef struct packed {logic one; tri_pin_s hi; tri_pin_s lo; logic [6:0] a;} map_s;
   logic               clk, rst_n, done, one_pin, scl, scl_oe, hoe, oe, hs, gc, ok;
   logic signed [12:0] data, d;
   logic [1:0]         res;
   logic [11:0]        result;
   logic [6:0]         taddr;
   logic [7:0]         b;
   logic [15:0]        v, seen, e_v;
   logic [15:0]        exp_q[$];
   tri_pin_s           pin_lo, pin_hi;
   int                 bad_count, checked, seed, gc_n;
   event               seen_ev;
   wire                sda = ~(hoe | oe);
   wire                scl_w = scl & ~scl_oe;
   logic signed [12:0] tv[8] = '{13'sd400, -13'sd400, 13'sd2047, 13'sd2500,
                                 -13'sd2048, -13'sd3000, 13'sd4, -13'sd4};
   map_s               maps[11] = '{'{0,1,1,'h4e}, '{0,0,2,'h49}, '{0,0,1,'h4a},
      '{0,1,0,'h4c}, '{0,1,2,'h4d}, '{0,0,0,'h48}, '{0,2,0,'h4b}, '{0,2,1,'h4f},
      '{1,1,0,'h48}, '{1,2,2,'h49}, '{1,0,1,'h4a}};

   temp_sensor_i2c_target u_dut (.CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl_w), .SCL_O(),
      .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE_O(oe),
      .ADDR_SELECT_PIN_LO_I(pin_lo), .ADDR_SELECT_PIN_HI_I(pin_hi),
      .ONE_PIN_VARIANT_I(one_pin), .CONV_DONE_I(done), .CONV_DATA_I(data),
      .RES_SEL_I(res), .TEMP_RESULT_O(result), .TARGET_ADDR_O(taddr), .HS_MODE_O(hs),
      .GC_RESET_O(gc));
   i2c_ctrl_model u_host (.sda_i(sda), .scl_o(scl), .sda_oe_o(hoe));

   // ****
   // helpers
   // ****
   function automatic logic [11:0] fmt(logic signed [12:0] x, logic [1:0] r);
      logic [11:0] w;
      w = (x > 13'sd2047) ? 12'h7ff : (x < -13'sd2048) ? 12'h800 : x[11:0];
      return w & (12'hfff << (2'h3 - r));
   endfunction
   task automatic note(input logic [15:0] e, input logic [15:0] a);
      exp_q.push_back(e);
      seen = a;
      -> seen_ev;
      #1;
   endtask
   task automatic conv_in(input logic signed [12:0] x, input logic [1:0] r);
      @(negedge clk);
      data = x;
      res = r;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, output logic [15:0] rv, output logic ack);
      logic [7:0] rb;
      logic       x;
      @(negedge clk);
      u_host.start();
      u_host.xfer({a, 1'b1}, 1'b1, rb, ack);
      rv = 16'h0000;
      for (int i = 0; i < 2 && ack; i++) begin
         u_host.xfer(8'hff, i == 1, rb, x);
         rv = {rv[7:0], rb};
      end
      u_host.stop();
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] q,
                     output logic ack);
      logic [7:0] rb;
      logic       k1, k2;
      @(negedge clk);
      u_host.start();
      u_host.xfer({a, 1'b0}, 1'b1, rb, ack);
      u_host.xfer(p, 1'b1, rb, k1);
      u_host.xfer(q, 1'b1, rb, k2);
      u_host.stop();
      ack = ack & k1;
   endtask
   task automatic results();
      $display("checks %0d, failures %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ****
   // clock, checker, watchdog
   // ****
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial forever begin
      @(seen_ev);
      e_v = exp_q.pop_front();
      `CHK(e_v, seen)
   end
   // counts every reset pulse, so a relatch-only command that pulses shows up
   always @(posedge clk) if (gc === 1'b1) gc_n <= gc_n + 1;
   initial begin
      #1ms;
      bad_count++;
      results();
   end

   // ****
   // tests
   // ****
   initial begin
      rst_n = 1'b0;
      done = 1'b0;
      data = '0;
      res = 2'h3;
      one_pin = 1'b0;
      pin_lo = '0;
      pin_hi = '0;
      seed = 34;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (20) @(negedge clk);
      rd(7'h48, v, ok);
      note(16'h0001, {15'h0, ok});
      note(16'h0000, v);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         d = (i < 8) ? tv[i] : 13'($random(seed) % 2200);
         conv_in(d, i[1:0]);
         rd(7'h48, v, ok);
         note({fmt(d, i[1:0]), 4'h0}, v);
      end
      $display("test results done");
      wr(7'h48, 8'h00, 8'h5a, ok);
      note(16'h0001, {15'h0, ok});
      rd(7'h48, v, ok);
      note({fmt(d, 2'h3), 4'h0}, v);
      wr(7'h48, 8'h01, 8'h00, ok);
      rd(7'h48, v, ok);
      note(16'h0000, v);
      wr(7'h48, 8'h00, 8'h00, ok);
      rd(7'h4a, v, ok);
      note(16'h0000, {15'h0, ok});
      $display("test pointer done");
      @(negedge clk);
      u_host.start();
      u_host.xfer(8'h0b, 1'b1, b, ok);
      repeat (8) @(negedge clk);
      note(16'h0001, {14'h0, ok, hs});
      @(negedge clk);
      u_host.stop();
      repeat (10) @(negedge clk);
      note(16'h0000, {15'h0, hs});
      $display("test fast switch done");
      foreach (maps[i]) begin
         @(negedge clk);
         pin_hi = maps[i].hi;
         pin_lo = maps[i].lo;
         one_pin = maps[i].one;
         repeat (8) @(negedge clk);
         note({9'h0, (i == 0) ? 7'h48 : maps[i-1].a}, {9'h0, taddr});
         wr(7'h00, 8'h04, 8'h00, ok);
         note({9'h0, maps[i].a}, {9'h0, taddr});
         rd(maps[i].a, v, b[0]);
         note(16'h0003, {14'h0, ok, b[0]});
      end
      $display("test address map done");
      @(negedge clk);
      pin_lo = '0;
      pin_hi = '0;
      one_pin = 1'b0;
      conv_in(13'sd400, 2'h3);
      wr(7'h00, 8'h06, 8'h00, ok);
      rd(7'h48, v, b[0]);
      note(16'h0007, {13'h0, gc_n == 1, ok, b[0]});
      note(16'h0000, v);
      $display("test general reset done");
      results();
   end
endmodule // test_temp_sensor_i2c_target
